// *** rtl/dmt_symbol_modulator.sv ***
`timescale 1ns/10ps
module dmt_symbol_modulator
    import dmt_pkg::*;
(
    input  wire logic                     clock,
    input  wire logic                     rst,
    input  wire logic                     z_valid,
    output logic                          z_ready,
    input  wire logic [FIDX_W-1:0]        z_index,
    input  wire logic signed [SAMP_W-1:0] z_re,
    input  wire logic signed [SAMP_W-1:0] z_im,
    input  wire logic                     z_last,
    input  wire logic [2:0]               size_n,
    input  wire logic [FIDX_W-1:0]        highest_loaded_index,
    input  wire logic [EXT_W-1:0]         prefix_length,
    input  wire logic [EXT_W-1:0]         suffix_length,
    input  wire logic [BETA_W-1:0]        beta,
    input  wire logic                     spacing_sel,
    input  wire logic                     showtime,
    input  wire logic                     sync_mode,
    input  wire logic                     sync_start,
    input  wire logic                     pilot_wr,
    input  wire logic [SLOT_W-1:0]        pilot_slot,
    input  wire logic [FIDX_W-1:0]        pilot_index,
    input  wire logic                     pilot_enable,
    input  wire logic signed [SAMP_W-1:0] pilot_level,
    output logic                          x_valid,
    input  wire logic                     x_ready,
    output logic signed [SAMP_W-1:0]      x_sample,
    output logic                          x_symbol_start,
    output logic                          sync_slot,
    output logic                          sample_clock_sel,
    output logic                          config_error,
    output logic                          sync_miss
);

    ////////////////////////////////////////////////////////////////////////////////
    // storage
    logic signed [SAMP_W-1:0] freq_re [FREQ_DEPTH];
    logic signed [SAMP_W-1:0] freq_im [FREQ_DEPTH];
    logic signed [SAMP_W-1:0] xbuf    [TIME_DEPTH];
    logic signed [SAMP_W-1:0] tail    [TAIL_DEPTH];
    logic [FIDX_W-1:0]        pilot_idx [PILOT_SLOTS];
    logic                     pilot_on  [PILOT_SLOTS];

    dmt_state_t               state;
    logic [CNT_W-1:0]         cnt;
    logic [FIDX_W-1:0]        tone;
    logic [TIDX_W-1:0]        ph;
    logic signed [ACC_W-1:0]  acc;
    logic [SLOT_W-1:0]        slot;
    logic [SYM_CNT_W-1:0]     sym_count;
    logic                     tail_ok;

    logic [FIFO_W-1:0]        f_data;
    logic                     f_valid;
    logic                     f_ready;
    logic                     f_last;
    logic [FIDX_W-1:0]        f_idx;
    logic signed [SAMP_W-1:0] f_re;
    logic signed [SAMP_W-1:0] f_im;

    ////////////////////////////////////////////////////////////////////////////////
    // entry buffer from the symbol encoder
    assign f_ready = state == S_LOAD;
    assign {f_last, f_idx, f_re, f_im} = f_data;

    dmt_fifo #(
        .WIDTH (FIFO_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clock     (clock),
        .rst       (rst),
        .in_valid  (z_valid),
        .in_ready  (z_ready),
        .in_data   ({z_last, z_index, z_re, z_im}),
        .out_valid (f_valid),
        .out_ready (f_ready),
        .out_data  (f_data)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // sizes and configuration check
    logic [TIDX_W-1:0] n_half;
    logic [TIDX_W-1:0] t_mask;
    logic [CNT_W-1:0]  two_n;
    logic [CNT_W-1:0]  lce;
    logic [CNT_W-1:0]  lce_m;
    logic [CNT_W-1:0]  lce_rem;
    logic [CNT_W-1:0]  sym_total;
    logic [CNT_W-1:0]  out_total;
    logic [BETA_W-1:0] beta_cap;
    logic              cfg_bad;

    assign n_half = N_MIN << size_n;
    assign two_n = {1'b0, n_half} << 1;
    assign t_mask = TIDX_W'(two_n - CNT_W'(1));
    assign lce = CNT_W'(prefix_length) + CNT_W'(suffix_length) - CNT_W'(beta);
    assign lce_m = lce >> size_n;
    assign lce_rem = lce & ((CNT_W'(1) << size_n) - CNT_W'(1));
    assign sym_total = CNT_W'(prefix_length) + two_n + CNT_W'(suffix_length);
    assign out_total = sym_total - CNT_W'(beta);
    assign beta_cap = ((n_half >> 4) > TIDX_W'(BETA_MAX)) ? BETA_MAX : BETA_W'(n_half >> 4);

    always_comb
    begin
        cfg_bad = 1'b0;
        if (CNT_W'(highest_loaded_index) >= CNT_W'(n_half))
            cfg_bad = 1'b1;
        if (beta > beta_cap)
            cfg_bad = 1'b1;
        if (EXT_W'(beta) >= prefix_length || EXT_W'(beta) >= suffix_length)
            cfg_bad = 1'b1;
        if (lce_rem != '0 || lce_m < CE_M_MIN || lce_m > CE_M_MAX)
            cfg_bad = 1'b1;
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            config_error <= 1'b0;
        else
            config_error <= cfg_bad;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // twiddle from the 7-bit phase circle
    function automatic logic signed [SAMP_W-1:0] sin_of(input logic [PH_W-1:0] q);
        logic [TAB_W-1:0]         j;
        logic signed [SAMP_W-1:0] m;
        j = q[5] ? TAB_TOP - {1'b0, q[4:0]} : {1'b0, q[4:0]};
        m = signed'(SINE_Q[j]);
        sin_of = q[6] ? -m : m;
    endfunction

    logic [TIDX_W-1:0]        ph_norm;
    logic [PH_W-1:0]          q;
    logic signed [SAMP_W-1:0] tw_sin;
    logic signed [SAMP_W-1:0] tw_cos;
    logic signed [SAMP_W-1:0] tz_re;
    logic signed [SAMP_W-1:0] tz_im;
    logic signed [32:0]       prod;
    logic signed [ACC_W-1:0]  next_acc;
    logic                     last_tone;
    logic                     last_sample;

    assign ph_norm = ph << (SIZE_N_MAX - size_n);
    assign q = ph_norm[TIDX_W-1 -: PH_W];
    assign tw_sin = sin_of(q);
    assign tw_cos = sin_of(q + QUARTER);
    assign tz_re = freq_re[tone];
    assign tz_im = freq_im[tone];
    // mirrored half folds into twice the real part
    assign prod = 33'(tz_re * tw_cos) - 33'(tz_im * tw_sin);
    assign next_acc = acc + ACC_W'(prod);
    assign last_tone = tone == FIDX_W'(n_half - TIDX_W'(1));
    assign last_sample = cnt == two_n - CNT_W'(1);

    ////////////////////////////////////////////////////////////////////////////////
    // pilot table
    logic is_sync;
    logic pilot_ok;

    assign is_sync = sym_count == SYNC_SLOT;
    assign pilot_ok = pilot_on[slot] && showtime && !is_sync && pilot_idx[slot] != '0
                      && pilot_idx[slot] <= highest_loaded_index;

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            for (int k = 0; k < PILOT_SLOTS; k++)
            begin
                pilot_idx[k] <= '0;
                pilot_on[k]  <= 1'b0;
            end
        end
        else if (pilot_wr)
        begin
            pilot_idx[pilot_slot] <= pilot_index;
            pilot_on[pilot_slot]  <= pilot_enable;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // frequency vector writes
    logic                     fw_en;
    logic [FIDX_W-1:0]        fw_addr;
    logic signed [SAMP_W-1:0] fw_re;
    logic signed [SAMP_W-1:0] fw_im;

    always_comb
    begin
        fw_en = 1'b0;
        fw_addr = cnt[FIDX_W-1:0];
        fw_re = '0;
        fw_im = '0;
        if (state == S_CLEAR)
            fw_en = 1'b1;
        else if (state == S_LOAD && f_valid && f_idx != '0 && f_idx <= highest_loaded_index)
        begin
            fw_en = 1'b1;
            fw_addr = f_idx;
            fw_re = f_re;
            fw_im = f_im;
        end
        else if (state == S_PILOT && pilot_ok)
        begin
            fw_en = 1'b1;
            fw_addr = pilot_idx[slot];
            fw_re = pilot_level;
            fw_im = pilot_level;
        end
    end

    always_ff @(posedge clock)
    begin
        if (fw_en)
        begin
            freq_re[fw_addr] <= fw_re;
            freq_im[fw_addr] <= fw_im;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // group start alignment
    logic                  sync_meta;
    logic                  sync_level;
    logic                  sync_prev;
    logic [SYNC_TOL_W-1:0] tol;
    logic                  sync_rise;
    logic                  in_wait;
    logic                  start;

    assign sync_rise = sync_level && !sync_prev;
    assign in_wait = state == S_WAIT;
    assign start = in_wait && !config_error && (!sync_mode || sync_rise || tol != '0);

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            sync_meta  <= 1'b0;
            sync_level <= 1'b0;
            sync_prev  <= 1'b0;
        end
        else
        begin
            sync_meta  <= sync_start;
            sync_level <= sync_meta;
            sync_prev  <= sync_level;
        end
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            tol <= '0;
        else if (sync_rise && !in_wait)
            tol <= SYNC_TOL_CYC;
        else if (in_wait)
            tol <= '0;
        else if (tol != '0)
            tol <= tol - 1'b1;
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            sync_miss <= 1'b0;
        else if (sync_mode && tol == SYNC_TOL_W'(1) && !in_wait)
            sync_miss <= 1'b1;
        else if (start)
            sync_miss <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // emission datapath
    logic [TIDX_W-1:0]        src;
    logic signed [SAMP_W-1:0] body;
    logic signed [SAMP_W-1:0] half;
    logic signed [SAMP_W-1:0] tail_rd;
    logic                     in_head;
    logic                     in_tail;
    logic                     emit_go;
    logic                     emit_out;
    logic                     emit_last;

    assign src = TIDX_W'(cnt + two_n - CNT_W'(prefix_length)) & t_mask;
    assign body = xbuf[src];
    assign half = body >>> 1;
    assign tail_rd = tail_ok ? tail[cnt[BETA_W-1:0]] : '0;
    assign in_head = cnt < CNT_W'(beta);
    assign in_tail = cnt >= out_total;
    assign emit_go = state == S_EMIT && (!x_valid || x_ready);
    assign emit_out = emit_go && !in_tail;
    assign emit_last = emit_go && cnt == sym_total - CNT_W'(1);

    always_ff @(posedge clock)
    begin
        if (state == S_IDFT && last_tone)
            xbuf[cnt[TIDX_W-1:0]] <= next_acc[OUT_LSB +: SAMP_W];
        if (emit_go && in_tail)
            tail[BETA_W'(cnt - out_total)] <= half;
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            tail_ok <= 1'b0;
        else if (emit_last)
            tail_ok <= 1'b1;
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            x_valid        <= 1'b0;
            x_sample       <= '0;
            x_symbol_start <= 1'b0;
        end
        else if (emit_out)
        begin
            x_valid        <= 1'b1;
            x_sample       <= in_head ? SAMP_W'(half + tail_rd) : body;
            x_symbol_start <= cnt == '0;
        end
        else if (x_ready)
        begin
            x_valid        <= 1'b0;
            x_symbol_start <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // superframe position and per-symbol flags
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            sym_count <= '0;
        else if (!showtime)
            sym_count <= '0;
        else if (emit_last)
            sym_count <= is_sync ? '0 : sym_count + 1'b1;
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            sync_slot        <= 1'b0;
            sample_clock_sel <= SPACING_LOW;
        end
        else if (start)
        begin
            sync_slot        <= is_sync;
            sample_clock_sel <= spacing_sel;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // symbol sequencer
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            state <= S_CLEAR;
            cnt   <= '0;
            tone  <= FIDX_W'(1);
            ph    <= '0;
            acc   <= '0;
            slot  <= '0;
        end
        else
        begin
            unique case (state)
                S_CLEAR:
                begin
                    if (cnt != CNT_W'(n_half) - CNT_W'(1))
                        cnt <= cnt + 1'b1;
                    else if (!config_error)
                    begin
                        state <= S_LOAD;
                        cnt   <= '0;
                    end
                end
                S_LOAD:
                begin
                    if (f_valid && f_last)
                    begin
                        state <= S_PILOT;
                        slot  <= '0;
                    end
                end
                S_PILOT:
                begin
                    slot <= slot + 1'b1;
                    if (slot == LAST_SLOT)
                    begin
                        state <= S_IDFT;
                        cnt   <= '0;
                        tone  <= FIDX_W'(1);
                        ph    <= '0;
                        acc   <= '0;
                    end
                end
                S_IDFT:
                begin
                    if (last_tone)
                    begin
                        acc  <= '0;
                        tone <= FIDX_W'(1);
                        ph   <= TIDX_W'(cnt + CNT_W'(1)) & t_mask;
                        if (last_sample)
                        begin
                            state <= S_WAIT;
                            cnt   <= '0;
                        end
                        else
                            cnt <= cnt + 1'b1;
                    end
                    else
                    begin
                        acc  <= next_acc;
                        tone <= tone + 1'b1;
                        ph   <= (ph + TIDX_W'(cnt)) & t_mask;
                    end
                end
                S_WAIT:
                begin
                    if (start)
                    begin
                        state <= S_EMIT;
                        cnt   <= '0;
                    end
                end
                S_EMIT:
                begin
                    if (emit_last)
                    begin
                        state <= S_CLEAR;
                        cnt   <= '0;
                    end
                    else if (emit_go)
                        cnt <= cnt + 1'b1;
                end
                default:
                begin
                    state <= S_CLEAR;
                    cnt   <= '0;
                end
            endcase
        end
    end

endmodule

// *** include/dmt_pkg.sv ***
package dmt_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // widths
    localparam int SAMP_W    = 16;
    localparam int FIDX_W    = 12;
    localparam int TIDX_W    = 13;
    localparam int CNT_W     = 14;
    localparam int EXT_W     = 12;
    localparam int BETA_W    = 8;
    localparam int ACC_W     = 48;
    localparam int SLOT_W    = 4;
    localparam int SYM_CNT_W = 9;
    localparam int PH_W      = 7;
    localparam int TAB_W     = 6;
    localparam int FIFO_W    = 1 + FIDX_W + 2 * SAMP_W;

    ////////////////////////////////////////////////////////////////////////////////
    // depths and transform sizes
    localparam int FIFO_DEPTH  = 8;
    localparam int FREQ_DEPTH  = 4096;
    localparam int TIME_DEPTH  = 8192;
    localparam int TAIL_DEPTH  = 256;
    localparam int PILOT_SLOTS = 16;
    localparam logic [SLOT_W-1:0] LAST_SLOT  = 4'hf;
    localparam logic [TIDX_W-1:0] N_MIN      = 13'h0020;
    localparam logic [2:0]        SIZE_N_MAX = 3'h7;
    localparam logic [BETA_W-1:0] BETA_MAX   = 8'hff;
    localparam logic [CNT_W-1:0]  CE_M_MIN   = 14'h0002;
    localparam logic [CNT_W-1:0]  CE_M_MAX   = 14'h0010;
    localparam int OUT_LSB = 14;

    ////////////////////////////////////////////////////////////////////////////////
    // tone spacing codes, in millihertz, and superframe
    localparam logic SPACING_LOW  = 1'b0;
    localparam logic SPACING_HIGH = 1'b1;
    localparam int   SPACING_LOW_MHZ  = 4312500;
    localparam int   SPACING_HIGH_MHZ = 8625000;
    localparam int   SPACING_TOL_PPM  = 50;
    localparam logic [SYM_CNT_W-1:0] SYNC_SLOT = 9'h100;

    ////////////////////////////////////////////////////////////////////////////////
    // timing of group alignment
    localparam int CLK_PERIOD_NS = 40;
    localparam int SYNC_TOL_NS   = 1000;
    localparam int SYNC_TOL_W    = 6;
    localparam logic [SYNC_TOL_W-1:0] SYNC_TOL_CYC = SYNC_TOL_W'(SYNC_TOL_NS / CLK_PERIOD_NS);

    ////////////////////////////////////////////////////////////////////////////////
    // quarter sine, 32 steps per quadrant
    localparam logic [PH_W-1:0] QUARTER = 7'h20;
    localparam logic [TAB_W-1:0] TAB_TOP = 6'h20;
    localparam logic [SAMP_W-1:0] SINE_Q [0:32] = '{
        16'h0000, 16'h0648, 16'h0c8c, 16'h12c8, 16'h18f9, 16'h1f1a, 16'h2528, 16'h2b1f,
        16'h30fb, 16'h36ba, 16'h3c56, 16'h41ce, 16'h471c, 16'h4c3f, 16'h5133, 16'h55f5,
        16'h5a82, 16'h5ed7, 16'h62f1, 16'h66cf, 16'h6a6d, 16'h6dc9, 16'h70e2, 16'h73b5,
        16'h7641, 16'h7884, 16'h7a7c, 16'h7c29, 16'h7d89, 16'h7e9c, 16'h7f61, 16'h7fd8,
        16'h7fff
    };

    typedef enum logic [5:0] {
        S_CLEAR = 6'h01,
        S_LOAD  = 6'h02,
        S_PILOT = 6'h04,
        S_IDFT  = 6'h08,
        S_WAIT  = 6'h10,
        S_EMIT  = 6'h20
    } dmt_state_t;

endpackage

// *** rtl/dmt_fifo.sv ***
`timescale 1ns/10ps
module dmt_fifo
    import dmt_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
)
(
    input  wire logic             clock,
    input  wire logic             rst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);

    localparam int PTR_W = $clog2(DEPTH);
    localparam logic [PTR_W:0] FULL = (PTR_W + 1)'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] rd_ptr;
    logic [PTR_W:0]   count;
    logic [PTR_W:0]   next_count;
    logic             push;
    logic             pop;

    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem[rd_ptr];

    always_comb
    begin
        next_count = count;
        if (push && !pop)
            next_count = count + 1'b1;
        else if (pop && !push)
            next_count = count - 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // storage
    always_ff @(posedge clock)
    begin
        if (push)
            mem[wr_ptr] <= in_data;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // pointers and flags
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            wr_ptr    <= '0;
            rd_ptr    <= '0;
            count     <= '0;
            in_ready  <= 1'b0;
            out_valid <= 1'b0;
        end
        else
        begin
            if (push)
                wr_ptr <= wr_ptr + 1'b1;
            if (pop)
                rd_ptr <= rd_ptr + 1'b1;
            count     <= next_count;
            in_ready  <= next_count != FULL;
            out_valid <= next_count != '0;
        end
    end

endmodule

// *** testbench/dmt_symbol_modulator_asserts.sv ***
`timescale 1ns/10ps
module dmt_symbol_modulator_asserts import dmt_pkg::*;
(
    input wire logic                     clock,
    input wire logic                     rst,
    input wire logic [2:0]               size_n,
    input wire logic [FIDX_W-1:0]        highest_loaded_index,
    input wire logic [EXT_W-1:0]         prefix_length,
    input wire logic [EXT_W-1:0]         suffix_length,
    input wire logic [BETA_W-1:0]        beta,
    input wire logic                     spacing_sel,
    input wire logic                     showtime,
    input wire logic                     x_valid,
    input wire logic                     x_ready,
    input wire logic signed [SAMP_W-1:0] x_sample,
    input wire logic                     x_symbol_start,
    input wire logic                     sync_slot,
    input wire logic                     sample_clock_sel,
    input wire logic                     config_error
);
    logic [CNT_W-1:0] n2, ext, cnt;
    assign n2  = (CNT_W'(N_MIN) << size_n) << 1;
    assign ext = CNT_W'(prefix_length) + CNT_W'(suffix_length) - CNT_W'(beta);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);
    sequence s_stall;
        x_valid && !x_ready;
    endsequence
    sequence s_take_start;
        x_valid && x_ready && x_symbol_start;
    endsequence
    // samples taken since the last symbol start
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            cnt <= '0;
        else if (x_valid && x_ready)
            cnt <= x_symbol_start ? CNT_W'(1) : cnt + 1'b1;
    end
    AST_HOLD: assert property (s_stall |=> x_valid && $stable(x_sample))
        else $error("sample changed while stalled");
    AST_BETA: assert property (CNT_W'(beta) > (n2 >> 5) |=> config_error)
        else $error("oversize window not flagged");
    AST_ORDER: assert property (EXT_W'(beta) >= prefix_length ||
        EXT_W'(beta) >= suffix_length |=> config_error)
        else $error("window not below extensions");
    AST_TOP: assert property (CNT_W'(highest_loaded_index) >= (n2 >> 1) |=> config_error)
        else $error("top tone not flagged");
    AST_EXT: assert property (ext % (n2 >> 6) != 0 || ext < 2 * (n2 >> 6) ||
        ext > 16 * (n2 >> 6) |=> config_error)
        else $error("bad extension not flagged");
    AST_SYMLEN: assert property (s_take_start |-> cnt == 0 || cnt == n2 + ext)
        else $error("wrong symbol length");
    AST_CLKSEL: assert property (x_valid |-> sample_clock_sel == spacing_sel)
        else $error("spacing select not echoed");
    AST_NOSYNC: assert property (!showtime [*2] |-> !sync_slot)
        else $error("sync slot outside showtime");
endmodule
bind dmt_symbol_modulator dmt_symbol_modulator_asserts i_dmt_symbol_modulator_asserts (.*);

// *** testbench/dmt_sink.sv ***
`timescale 1ns/10ps
module dmt_sink import dmt_pkg::*;
(
    input  wire logic                     clock,
    input  wire logic                     rst,
    input  wire logic                     slow,
    input  wire logic                     x_valid,
    output logic                          x_ready,
    input  wire logic signed [SAMP_W-1:0] x_sample
);
    logic [1:0]               stall;
    int                       pos;
    logic signed [SAMP_W-1:0] smp [0:137];
    // when slow, accept one cycle in four
    assign x_ready = !slow || stall == 2'h0;
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            stall <= 2'h0;
        else
            stall <= stall + 2'h1;
    end
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            pos <= 0;
        else if (x_valid && x_ready && pos < 138)
        begin
            smp[pos] <= x_sample;
            pos      <= pos + 1;
        end
    end
endmodule

// *** testbench/tb_dmt_symbol_modulator.sv ***
`timescale 1ns/10ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_mismatch++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_dmt_symbol_modulator
    import dmt_pkg::*;
;
    logic clock = 1'b0, rst = 1'b1, slow = 1'b0, z_valid = 1'b0, z_last = 1'b0;
    logic spacing_sel = 1'b0, showtime = 1'b0, sync_mode = 1'b0, sync_start = 1'b0;
    logic pilot_wr = 1'b0, pilot_enable = 1'b0;
    logic [2:0] size_n = 3'h0;
    logic [SLOT_W-1:0] pilot_slot = 4'h0;
    logic [FIDX_W-1:0] z_index = 12'h000, highest_loaded_index = 12'h014, pilot_index = 12'h005;
    logic signed [SAMP_W-1:0] z_re = 16'sh0000, z_im = 16'sh0000, pilot_level = 16'sh03e8;
    logic [EXT_W-1:0] prefix_length = 12'h004, suffix_length = 12'h003;
    logic [BETA_W-1:0] beta = 8'h02;
    logic z_ready, x_valid, x_ready, x_symbol_start, sync_slot, sample_clock_sel;
    logic config_error, sync_miss;
    logic signed [SAMP_W-1:0] x_sample;
    logic signed [SAMP_W-1:0] s [0:137];
    int n_mismatch = 0, check_count = 0, cycles = 0;

    dmt_symbol_modulator i_dmt_symbol_modulator (.*);
    dmt_sink i_dmt_sink (.*);

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        forever #20 clock = ~clock;
    end
    always @(posedge clock)
    begin
        if (++cycles == 60000)
        begin
            n_mismatch++;
            end_sim();
        end
    end
    task automatic end_sim();
        $display("mismatches %0d checks %0d", n_mismatch, check_count);
        if (n_mismatch == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic restart(input logic sp, sl);
        rst = 1'b1;
        spacing_sel = sp;
        slow = sl;
        repeat (8) @(negedge clock);
        rst = 1'b0;
    endtask
    task automatic send(input logic [FIDX_W-1:0] i, input logic signed [SAMP_W-1:0] re,
        input logic last);
        z_valid = 1'b1;
        z_index = i;
        z_re = re;
        z_last = last;
        do @(posedge clock); while (z_ready !== 1'b1);
        @(negedge clock);
    endtask
    task automatic wait_out(input int n);
        z_valid = 1'b0;
        while (i_dmt_sink.pos < n)
            @(negedge clock);
        s = i_dmt_sink.smp;
    endtask
    task automatic bad(input logic [7:0] b, input logic [11:0] p, q, h);
        beta = b;
        prefix_length = p;
        suffix_length = q;
        highest_loaded_index = h;
        repeat (2) @(negedge clock);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_zero();
        restart(1'b0, 1'b0);
        repeat (2)
        begin
            send(12'h000, 16'sh7fff, 1'b0);
            send(12'h019, 16'sh7fff, 1'b1);
        end
        wait_out(138);
        for (int k = 0; k < 138; k++)
            `CHK(s[k], 16'sh0000)
    endtask
    task automatic t_tone();
        restart(1'b1, 1'b1);
        send(12'h005, 16'sh03e8, 1'b1);
        send(12'h005, 16'sh03e8, 1'b1);
        wait_out(138);
        `CHK(sample_clock_sel, 1'b1)
        `CHK(s[4] != 16'sh0000, 1'b1)
        `CHK(s[2], s[66])
        `CHK(s[3], s[67])
        `CHK(s[68], s[4])
        `CHK(s[69] - s[0], s[5] >>> 1)
        for (int k = 1; k < 32; k++)
            `CHK(s[4 + k], s[68 - k])
        for (int k = 2; k < 69; k++)
            `CHK(s[69 + k], s[k])
    endtask
    task automatic t_fifo();
        restart(1'b0, 1'b1);
        send(12'h003, 16'sh1000, 1'b1);
        z_valid = 1'b0;
        repeat (200) @(negedge clock);
        for (int k = 1; k <= 8; k++)
            send(FIDX_W'(k), 16'sh0100, 1'b0);
        `CHK(z_ready, 1'b0)
        wait_out(69);
        repeat (60) @(negedge clock);
        `CHK(z_ready, 1'b1)
    endtask
    task automatic t_cfg();
        bad(8'h03, 12'h004, 12'h004, 12'h014);
        `CHK(config_error, 1'b1)
        bad(8'h02, 12'h002, 12'h005, 12'h014);
        `CHK(config_error, 1'b1)
        bad(8'h02, 12'h00a, 12'h009, 12'h014);
        `CHK(config_error, 1'b1)
        bad(8'h02, 12'h004, 12'h003, 12'h020);
        `CHK(config_error, 1'b1)
        bad(8'h02, 12'h004, 12'h003, 12'h014);
        restart(1'b0, 1'b0);
        @(negedge clock);
        `CHK(config_error, 1'b0)
    endtask
    task automatic t_pilot();
        showtime = 1'b1;
        sync_mode = 1'b1;
        pilot_enable = 1'b1;
        pilot_wr = 1'b1;
        @(negedge clock);
        pilot_wr = 1'b0;
        send(12'h000, 16'sh0000, 1'b1);
        z_valid = 1'b0;
        repeat (2500) @(negedge clock);
        `CHK(x_valid, 1'b0)
        sync_start = 1'b1;
        repeat (4) @(negedge clock);
        sync_start = 1'b0;
        wait_out(69);
        `CHK(s[4] != 16'sh0000, 1'b1)
        `CHK(sync_miss, 1'b0)
    endtask

    initial
    begin
        t_zero();
        t_tone();
        t_fifo();
        t_cfg();
        t_pilot();
        end_sim();
    end
endmodule
